// *** frame_parser_pkg.sv ***
package frame_parser_pkg;
  localparam logic [7:0] START_MARK = 8'h7e;
  localparam logic [7:0] TYPE_IMMEDIATE = 8'h08;
  localparam logic [7:0] TYPE_QUEUED = 8'h09;
  localparam logic [7:0] TYPE_REMOTE = 8'h17;
  localparam logic [7:0] TYPE_LOCAL_RSP = 8'h88;
  localparam logic [7:0] TYPE_REMOTE_RSP = 8'h97;
  localparam logic [7:0] CSUM_GOOD = 8'hff;
  // byte positions within a frame
  localparam logic [15:0] POS_TYPE = 16'h0003;
  localparam logic [15:0] POS_ID = 16'h0004;
  localparam logic [15:0] POS_CMD_HI = 16'h0005;
  localparam logic [15:0] POS_CMD_LO = 16'h0006;
  localparam logic [15:0] POS_VALUE = 16'h0007;
  localparam logic [15:0] POS_ADDR_FIRST = 16'h0005;
  localparam logic [15:0] POS_ADDR_LAST = 16'h000c;
  localparam logic [15:0] POS_OPTIONS = 16'h000f;
  localparam logic [15:0] POS_RCMD_HI = 16'h0010;
  localparam logic [15:0] POS_RCMD_LO = 16'h0011;
  localparam logic [15:0] POS_RVALUE = 16'h0012;
  // length of a query frame, i.e. no parameter bytes
  localparam logic [15:0] LOCAL_QUERY_LEN = 16'h0004;
  localparam logic [15:0] REMOTE_QUERY_LEN = 16'h000f;
  localparam int OPT_NO_ACK_BIT = 0;
  localparam int OPT_APPLY_BIT = 1;
  localparam int OPT_SECURE_BIT = 4;
  localparam logic [7:0] OPT_UNUSED_MASK = 8'hec;
  localparam logic [63:0] BROADCAST_ADDR = 64'h0000_0000_0000_ffff;
  localparam logic [15:0] RESERVED_FIELD = 16'hfffe;
  localparam logic [15:0] APPLY_CHANGES_COMMAND = 16'h4143;
  localparam logic [15:0] SERIAL_RATE_SETTING = 16'h4244;
  localparam logic [15:0] MODULE_TEMPERATURE_QUERY = 16'h5450;
  localparam logic [15:0] CHANNEL_SETTING = 16'h4348;
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
  localparam logic [7:0] STATUS_BAD_PARAM = 8'h03;
  localparam int NUM_SLOT = 2;
  localparam logic [15:0] SLOT_CODE [NUM_SLOT] = '{SERIAL_RATE_SETTING, CHANNEL_SETTING};
  localparam logic [7:0] SLOT_RESET [NUM_SLOT] = '{8'h03, 8'h0c};
  localparam int RSP_MAX = 16;
  localparam logic [4:0] LOCAL_RSP_LEN = 5'h05;
  localparam logic [4:0] REMOTE_RSP_LEN = 5'h0f;
  typedef enum logic [2:0] {
    P_HUNT = 3'b000, P_LEN_HI = 3'b001, P_LEN_LO = 3'b010,
    P_BODY = 3'b011, P_CSUM = 3'b100
  } parse_state_type;
  typedef enum logic [1:0] {
    E_IDLE = 2'b00, E_HEAD = 2'b01, E_BODY = 2'b10, E_CSUM = 2'b11
  } emit_state_type;
endpackage

// *** byte_stream_if.sv ***
interface byte_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** two_entry_buffer.sv ***
module two_entry_buffer
  import frame_parser_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
)
(
  input wire logic clk,
  input wire logic rst,
  byte_stream_if.snk in_s,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // pointers wrap by overflow, so only powers of two serve
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("two_entry_buffer: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  assign in_s.ready = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_s.data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (push && !pop)
        count_ff <= count_ff + 1'b1;
      else if (pop && !push)
        count_ff <= count_ff - 1'b1;
    end
  end
endmodule // two_entry_buffer

// *** queued_at_command_frame_parser.sv ***
// Operation
// (RULE_01) frame begins at one-byte start marker
// (RULE_02) two-byte length counts bytes before checksum
// (RULE_03) type 0x09 is a queued local request
// (RULE_04) byte four is frame id; zero suppresses answer
// (RULE_05) bytes five, six name the command
// (RULE_06) parameter bytes are queued; none means query
// (RULE_07) checksum is 0xff minus sum from three
// (RULE_08) queued values wait for 0x08 or apply
// (RULE_09) active setting unchanged while change only queued
// (RULE_10) query has checksum right after command
// (RULE_11) queued query answers 0x88 with active value
// (RULE_12) 0x88 answer carries the request frame id
// (RULE_13) remote 0x17 answered by 0x97 with id
// (RULE_14) remote applies only with apply bit or later
// (RULE_15) host should send remote requests unicast only
// (RULE_16) broadcast remote unacknowledged; each node answers
// (RULE_17) remote layout: address, reserved, options, command
// (RULE_18) options: no-ack, apply, secure; rest zero
// (RULE_19) bad checksum discarded, then hunt for marker
// (RULE_20) shadow store copied to active in one step
module queued_at_command_frame_parser
  import frame_parser_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic [7:0] temp_value,
  output logic [7:0] serial_rate,
  output logic [NUM_SLOT*8-1:0] active_values,
  output logic pending_any,
  output logic frame_ok,
  output logic frame_bad,
  output logic remote_req,
  output logic [63:0] remote_dest,
  output logic [15:0] remote_cmd,
  output logic [7:0] remote_value,
  output logic remote_has_value,
  output logic remote_no_ack,
  output logic remote_apply,
  output logic remote_secure,
  input wire logic remote_rsp_valid,
  input wire logic [63:0] remote_rsp_addr,
  input wire logic [7:0] remote_rsp_status,
  input wire logic [7:0] remote_rsp_value,
  input wire logic remote_rsp_has_value,
  output logic remote_rsp_ready
);
  parse_state_type pstate_ff;
  emit_state_type estate_ff;
  logic [15:0] len_ff;
  logic [15:0] rem_ff;
  logic [15:0] pos_ff;
  logic [7:0] sum_ff;
  logic [7:0] type_ff;
  logic [7:0] id_ff;
  logic [15:0] cmd_ff;
  logic [7:0] val_ff;
  logic [63:0] addr_ff;
  logic [7:0] opt_ff;
  logic [7:0] rid_ff;
  logic [7:0] active_ff [NUM_SLOT];
  logic [7:0] shadow_ff [NUM_SLOT];
  logic [NUM_SLOT-1:0] pending_ff;
  logic [7:0] rsp_ff [RSP_MAX];
  logic [4:0] rsp_len_ff;
  logic [1:0] hcnt_ff;
  logic [4:0] bidx_ff;
  logic [7:0] esum_ff;
  logic rx_take;
  logic end_go;
  logic good;
  logic is_local;
  logic is_remote;
  logic is_query;
  logic is_apply;
  logic is_temp;
  logic [NUM_SLOT-1:0] hit;
  logic [7:0] hit_value;
  logic apply_all;
  logic local_go;
  logic remote_go;
  logic [7:0] status;
  logic has_value;
  logic [7:0] rsp_value;

  byte_stream_if #(.WIDTH(8)) emit_s ();

  assign rx_take = rx_valid && rx_ready;
  // only the last byte is held back while an answer drains, so the
  // answer store is never overwritten mid-send
  assign rx_ready = (pstate_ff != P_CSUM) || (estate_ff == E_IDLE);
  assign end_go = rx_take && (pstate_ff == P_CSUM);
  assign good = (8'(sum_ff + rx_data) == CSUM_GOOD); // see (RULE_07)
  assign is_local = ((type_ff == TYPE_QUEUED) || (type_ff == TYPE_IMMEDIATE))
    && (len_ff >= LOCAL_QUERY_LEN); // see (RULE_03)
  assign is_remote = (type_ff == TYPE_REMOTE) && (len_ff >= REMOTE_QUERY_LEN);
  assign is_query = is_local ? (len_ff == LOCAL_QUERY_LEN)
    : (len_ff == REMOTE_QUERY_LEN); // see (RULE_10)
  assign is_apply = (cmd_ff == APPLY_CHANGES_COMMAND);
  assign is_temp = (cmd_ff == MODULE_TEMPERATURE_QUERY);
  // any 0x08 set, or the apply command of either type, commits the queue
  assign apply_all = end_go && good && is_local
    && (is_apply || ((type_ff == TYPE_IMMEDIATE) && !is_query)); // see (RULE_08)
  assign local_go = end_go && good && is_local && (id_ff != 8'h00); // see (RULE_04)
  assign remote_rsp_ready = (estate_ff == E_IDLE) && !end_go;
  assign remote_go = remote_rsp_valid && remote_rsp_ready
    && (rid_ff != 8'h00); // see (RULE_04)
  assign serial_rate = active_ff[0]; // see (RULE_09)
  assign pending_any = |pending_ff;

  always_comb
  begin
    hit_value = 8'h00;
    for (int i = 0; i < NUM_SLOT; i++)
    begin
      hit[i] = (cmd_ff == SLOT_CODE[i]);
      if (hit[i])
        hit_value = active_ff[i];
    end
  end

  always_comb
  begin
    status = STATUS_BAD_CMD;
    has_value = 1'b0;
    rsp_value = hit_value; // see (RULE_11)
    if (is_apply || (|hit))
      status = STATUS_OK;
    else if (is_temp)
      status = is_query ? STATUS_OK : STATUS_BAD_PARAM;
    if (is_temp)
      rsp_value = temp_value;
    if (is_query && !is_apply && (status == STATUS_OK))
      has_value = 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pstate_ff <= P_HUNT;
      len_ff <= '0;
      rem_ff <= '0;
      pos_ff <= '0;
      sum_ff <= '0;
    end
    else if (rx_take)
    begin
      case (pstate_ff)
        P_HUNT:
        begin
          if (rx_data == START_MARK)
            pstate_ff <= P_LEN_HI; // see (RULE_01)
        end
        P_LEN_HI:
        begin
          len_ff[15:8] <= rx_data; // see (RULE_02)
          pstate_ff <= P_LEN_LO;
        end
        P_LEN_LO:
        begin
          len_ff[7:0] <= rx_data;
          rem_ff <= {len_ff[15:8], rx_data};
          pos_ff <= POS_TYPE;
          sum_ff <= 8'h00;
          pstate_ff <= ({len_ff[15:8], rx_data} == 16'h0000) ? P_HUNT : P_BODY;
        end
        P_BODY:
        begin
          sum_ff <= 8'(sum_ff + rx_data);
          rem_ff <= rem_ff - 16'h0001;
          if (pos_ff != 16'hffff)
            pos_ff <= pos_ff + 16'h0001;
          if (rem_ff == 16'h0001)
            pstate_ff <= P_CSUM;
        end
        P_CSUM:
          pstate_ff <= P_HUNT; // see (RULE_19)
        default:
          pstate_ff <= P_HUNT;
      endcase
    end
  end

  // field capture; the value keeps the last byte, i.e. the low byte
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      type_ff <= '0;
      id_ff <= '0;
      cmd_ff <= '0;
      val_ff <= '0;
      addr_ff <= '0;
      opt_ff <= '0;
    end
    else if (rx_take && (pstate_ff == P_BODY))
    begin
      if (pos_ff == POS_TYPE)
        type_ff <= rx_data;
      if (pos_ff == POS_ID)
        id_ff <= rx_data; // see (RULE_04)
      if (type_ff == TYPE_REMOTE)
      begin
        if (pos_ff >= POS_ADDR_FIRST && pos_ff <= POS_ADDR_LAST)
          addr_ff <= {addr_ff[55:0], rx_data}; // see (RULE_17)
        if (pos_ff == POS_OPTIONS)
          opt_ff <= rx_data;
        if (pos_ff == POS_RCMD_HI)
          cmd_ff[15:8] <= rx_data;
        if (pos_ff == POS_RCMD_LO)
          cmd_ff[7:0] <= rx_data;
        if (pos_ff >= POS_RVALUE)
          val_ff <= rx_data;
      end
      else
      begin
        if (pos_ff == POS_CMD_HI)
          cmd_ff[15:8] <= rx_data; // see (RULE_05)
        if (pos_ff == POS_CMD_LO)
          cmd_ff[7:0] <= rx_data;
        if (pos_ff >= POS_VALUE)
          val_ff <= rx_data; // see (RULE_06)
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SLOT; g++)
    begin : g_slot
      logic queue_wr;
      logic direct_wr;
      assign queue_wr = end_go && good && is_local && !is_query && hit[g]
        && (type_ff == TYPE_QUEUED); // see (RULE_06)
      assign direct_wr = end_go && good && is_local && !is_query && hit[g]
        && (type_ff == TYPE_IMMEDIATE);
      assign active_values[g*8 +: 8] = active_ff[g];

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          active_ff[g] <= SLOT_RESET[g];
          shadow_ff[g] <= SLOT_RESET[g];
          pending_ff[g] <= 1'b0;
        end
        else
        begin
          if (queue_wr)
            shadow_ff[g] <= val_ff; // see (RULE_20)
          // a direct write wins over a queued value of the same slot
          if (direct_wr)
            active_ff[g] <= val_ff;
          else if (apply_all && pending_ff[g])
            active_ff[g] <= shadow_ff[g]; // see (RULE_09)
          if (queue_wr)
            pending_ff[g] <= 1'b1;
          else if (apply_all || direct_wr)
            pending_ff[g] <= 1'b0; // see (RULE_08)
        end
      end
    end
  endgenerate

  // forwarded remote request; the radio side sends it and answers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      remote_req <= 1'b0;
      remote_dest <= '0;
      remote_cmd <= '0;
      remote_value <= '0;
      remote_has_value <= 1'b0;
      remote_no_ack <= 1'b0;
      remote_apply <= 1'b0;
      remote_secure <= 1'b0;
      rid_ff <= '0;
      frame_ok <= 1'b0;
      frame_bad <= 1'b0;
    end
    else
    begin
      frame_ok <= end_go && good;
      frame_bad <= end_go && !good; // see (RULE_19)
      remote_req <= end_go && good && is_remote
        && ((opt_ff & OPT_UNUSED_MASK) == 8'h00); // see (RULE_18)
      if (end_go && good && is_remote)
      begin
        remote_dest <= addr_ff;
        remote_cmd <= cmd_ff;
        remote_value <= val_ff;
        remote_has_value <= !is_query;
        // broadcasts carry no acknowledgement
        remote_no_ack <= opt_ff[OPT_NO_ACK_BIT]
          || (addr_ff == BROADCAST_ADDR); // see (RULE_16)
        remote_apply <= opt_ff[OPT_APPLY_BIT]; // see (RULE_14)
        remote_secure <= opt_ff[OPT_SECURE_BIT];
        rid_ff <= id_ff; // see (RULE_13)
      end
    end
  end

  // answer builder; each remote node answer makes its own 0x97 when the request frame id is nonzero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rsp_len_ff <= '0;
      for (int i = 0; i < RSP_MAX; i++)
        rsp_ff[i] <= 8'h00;
    end
    else if (local_go)
    begin
      rsp_ff[0] <= TYPE_LOCAL_RSP;
      rsp_ff[1] <= id_ff; // see (RULE_12)
      rsp_ff[2] <= cmd_ff[15:8];
      rsp_ff[3] <= cmd_ff[7:0];
      rsp_ff[4] <= status;
      rsp_ff[5] <= rsp_value; // see (RULE_11)
      rsp_len_ff <= LOCAL_RSP_LEN + {4'h0, has_value};
    end
    else if (remote_go)
    begin
      rsp_ff[0] <= TYPE_REMOTE_RSP; // see (RULE_13)
      rsp_ff[1] <= rid_ff;
      for (int k = 0; k < 8; k++)
        rsp_ff[2+k] <= remote_rsp_addr[63-8*k -: 8];
      rsp_ff[10] <= RESERVED_FIELD[15:8];
      rsp_ff[11] <= RESERVED_FIELD[7:0];
      rsp_ff[12] <= remote_cmd[15:8];
      rsp_ff[13] <= remote_cmd[7:0];
      rsp_ff[14] <= remote_rsp_status;
      rsp_ff[15] <= remote_rsp_value;
      rsp_len_ff <= REMOTE_RSP_LEN + {4'h0, remote_rsp_has_value};
    end
  end

  always_comb
  begin
    emit_s.valid = (estate_ff != E_IDLE);
    case (estate_ff)
      E_HEAD:
        emit_s.data = (hcnt_ff == 2'd0) ? START_MARK
          : (hcnt_ff == 2'd1) ? 8'h00 : {3'b000, rsp_len_ff};
      E_BODY:
        emit_s.data = rsp_ff[bidx_ff[3:0]];
      E_CSUM:
        emit_s.data = 8'(CSUM_GOOD - esum_ff); // see (RULE_07)
      default:
        emit_s.data = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      estate_ff <= E_IDLE;
      hcnt_ff <= '0;
      bidx_ff <= '0;
      esum_ff <= '0;
    end
    else
    begin
      case (estate_ff)
        E_IDLE:
        begin
          hcnt_ff <= 2'd0;
          if (local_go || remote_go)
            estate_ff <= E_HEAD;
        end
        E_HEAD:
        begin
          if (emit_s.ready)
          begin
            hcnt_ff <= hcnt_ff + 2'd1;
            bidx_ff <= 5'd0;
            esum_ff <= 8'h00;
            if (hcnt_ff == 2'd2)
              estate_ff <= E_BODY;
          end
        end
        E_BODY:
        begin
          if (emit_s.ready)
          begin
            esum_ff <= 8'(esum_ff + emit_s.data);
            bidx_ff <= bidx_ff + 5'd1;
            if (bidx_ff == rsp_len_ff - 5'd1)
              estate_ff <= E_CSUM;
          end
        end
        E_CSUM:
        begin
          if (emit_s.ready)
            estate_ff <= E_IDLE;
        end
        default:
          estate_ff <= E_IDLE;
      endcase
    end
  end

  // receiver stalls back up through the buffer into the emitter
  two_entry_buffer #(.WIDTH(8), .DEPTH(2)) two_entry_buffer_inst (
    .clk(clk),
    .rst(rst),
    .in_s(emit_s),
    .out_valid(tx_valid),
    .out_data(tx_data),
    .out_ready(tx_ready)
  );
endmodule // queued_at_command_frame_parser

// *** parser_asserts.sv ***
module parser_checker
  import frame_parser_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic [7:0] serial_rate,
  input wire logic [NUM_SLOT*8-1:0] active_values,
  input wire logic pending_any,
  input wire logic frame_ok,
  input wire logic frame_bad,
  input wire logic remote_req,
  input wire logic [63:0] remote_dest,
  input wire logic remote_no_ack,
  input wire logic remote_apply
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_bad_stable;
    frame_bad |-> $stable(active_values) && $stable(pending_any) ##1 $stable(active_values);
  endproperty
  a_bad_stable: assert property (p_bad_stable) else $error("state moved on bad frame");
  // shortest legal frame is five bytes, so two ends never sit closer
  property p_one_end;
    frame_ok |-> !frame_bad ##1 (!frame_ok && !frame_bad) [*4];
  endproperty
  a_one_end: assert property (p_one_end) else $error("frame end pulses too close");
  property p_active_on_ok;
    !$stable(active_values) |-> frame_ok;
  endproperty
  a_active_on_ok: assert property (p_active_on_ok) else $error("active moved off frame");
  property p_pend_rise;
    $rose(pending_any) |-> frame_ok && !frame_bad;
  endproperty
  a_pend_rise: assert property (p_pend_rise) else $error("pending rose off frame");
  property p_pend_fall;
    $fell(pending_any) |-> frame_ok;
  endproperty
  a_pend_fall: assert property (p_pend_fall) else $error("pending fell off frame");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("answer byte lost on stall");
  // the rate only moves on a committing frame, which empties the queue
  property p_rate_alias;
    !$stable(serial_rate) |-> frame_ok && !pending_any;
  endproperty
  a_rate_alias: assert property (p_rate_alias) else $error("serial rate moved off apply");
  property p_remote_ok;
    remote_req |-> frame_ok || $past(frame_ok);
  endproperty
  a_remote_ok: assert property (p_remote_ok) else $error("remote pulse off frame");
  property p_bcast;
    remote_req && remote_dest == BROADCAST_ADDR |-> remote_no_ack;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast not unacked");
  c_set: cover property ($rose(pending_any));
  c_bad: cover property (frame_bad);
  c_rapply: cover property (remote_req && remote_apply);
endmodule // parser_checker

bind queued_at_command_frame_parser parser_checker parser_checker_inst (
  .clk, .rst, .tx_valid, .tx_data, .tx_ready, .serial_rate, .active_values, .pending_any,
  .frame_ok, .frame_bad, .remote_req, .remote_dest, .remote_no_ack, .remote_apply
);

// *** host_model.sv ***
module host_model (
  input wire logic clk,
  input wire logic rst,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] bytes_type[$];
  bytes_type q;
  bytes_type got;
  logic took = 1'b0;
  logic stall = 1'b0;
  int tick = 0;
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end
  // bodies stay under 256 bytes, so the length high byte is zero
  function automatic void wrap(ref bytes_type f, input bytes_type body);
    logic [7:0] sum;
    sum = 8'h00;
    foreach (body[i])
      sum += body[i];
    f = {8'h7e, 8'h00, 8'(body.size()), body, 8'(8'hff - sum)};
  endfunction
  task automatic send(input bytes_type body, input logic [7:0] err);
    bytes_type f;
    wrap(f, body);
    f[f.size() - 1] ^= err;
    q = {q, f};
  endtask
  always @(posedge clk)
  begin
    if (!rst && rx_valid && rx_ready)
      took = 1'b1;
    if (!rst && tx_valid && tx_ready)
      got.push_back(tx_data);
  end
  // byte held until taken; idle data is scrambled, not left at the last value
  always @(negedge clk)
  begin
    if (took && q.size() > 0)
      void'(q.pop_front());
    took = 1'b0;
    tick++;
    tx_ready = !stall || (tick % 3 == 0);
    rx_valid = !rst && q.size() > 0;
    rx_data = rx_valid ? q[0] : ~rx_data;
  end
endmodule // host_model

// *** queued_at_command_frame_parser_tb.sv ***
`define chk(what, exp, seen) \
  begin \
    n_compared++; \
    if ((seen) !== (exp)) \
    begin \
      fails++; \
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen); \
    end \
  end

module queued_at_command_frame_parser_tb
  import frame_parser_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] bytes_type[$];
  localparam logic [63:0] DEST = 64'h0011_2233_4455_6677;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rx_valid, rx_ready, tx_valid, tx_ready, pending_any, frame_ok, frame_bad, remote_req;
  logic remote_has_value, remote_no_ack, remote_apply, remote_secure, remote_rsp_ready;
  logic remote_rsp_valid = 1'b0;
  logic remote_rsp_has_value = 1'b0;
  logic [7:0] rx_data, tx_data, serial_rate, remote_value;
  logic [7:0] temp_value = 8'h5a;
  logic [7:0] remote_rsp_status = 8'h00;
  logic [7:0] remote_rsp_value = 8'h00;
  logic [63:0] remote_dest;
  logic [63:0] remote_rsp_addr = 64'h0;
  logic [15:0] remote_cmd;
  logic [NUM_SLOT*8-1:0] active_values;
  int fails = 0, n_compared = 0, n_bad = 0, n_rreq = 0;

  queued_at_command_frame_parser queued_at_command_frame_parser_inst (
    .clk, .rst, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready, .temp_value,
    .serial_rate, .active_values, .pending_any, .frame_ok, .frame_bad, .remote_req, .remote_dest,
    .remote_cmd, .remote_value, .remote_has_value, .remote_no_ack, .remote_apply, .remote_secure,
    .remote_rsp_valid, .remote_rsp_addr, .remote_rsp_status, .remote_rsp_value,
    .remote_rsp_has_value, .remote_rsp_ready
  );
  host_model host_model_inst (
    .clk, .rst, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready
  );

  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    if (frame_bad === 1'b1)
      n_bad++;
    if (remote_req === 1'b1)
      n_rreq++;
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // waits out the host queue, then compares the whole answer stream
  task automatic judge(input bytes_type rsp);
    bytes_type exp;
    int n;
    exp = {};
    if (rsp.size() > 0)
      host_model_inst.wrap(exp, rsp);
    n = 0;
    while ((host_model_inst.q.size() > 0 || host_model_inst.got.size() < exp.size()) && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    repeat (10) @(negedge clk);
    `chk("answer length", exp.size(), host_model_inst.got.size())
    foreach (exp[i])
      if (i < host_model_inst.got.size())
        `chk("answer byte", exp[i], host_model_inst.got[i])
    host_model_inst.got.delete();
  endtask

  task automatic xfer(input bytes_type body, input logic [7:0] err, input bytes_type rsp);
    host_model_inst.send(body, err);
    judge(rsp);
  endtask

  task automatic node_rsp(input logic [63:0] a, input logic h, input logic [7:0] v,
                          input bytes_type rsp);
    int n;
    @(negedge clk);
    remote_rsp_valid = 1'b1;
    remote_rsp_addr = a;
    remote_rsp_has_value = h;
    remote_rsp_value = v;
    n = 0;
    #1;
    while (remote_rsp_ready !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      #1;
      n++;
    end
    @(negedge clk);
    remote_rsp_valid = 1'b0;
    remote_rsp_addr = ~a;
    remote_rsp_value = ~v;
    judge(rsp);
  endtask

  function automatic bytes_type rbody(input logic [7:0] typ, input logic [7:0] id,
                                     input logic [63:0] d, input bytes_type tail);
    bytes_type b;
    b = '{typ, id};
    for (int i = 7; i >= 0; i--)
      b.push_back(d[i*8+:8]);
    b = {b, 8'hff, 8'hfe, tail};
    return b;
  endfunction

  task automatic t_reset();
    `chk("rate", 8'h03, serial_rate)
    `chk("active", 16'h0c03, active_values)
    `chk("pending", 1'b0, pending_any)
  endtask

  task automatic t_queue();
    host_model_inst.stall = 1'b1;
    xfer('{TYPE_QUEUED, 8'h53, 8'h42, 8'h44, 8'h07}, 8'h00, '{TYPE_LOCAL_RSP, 8'h53, 8'h42, 8'h44, STATUS_OK});
    `chk("rate", 8'h03, serial_rate)
    `chk("pending", 1'b1, pending_any)
    xfer('{TYPE_QUEUED, 8'h21, 8'h42, 8'h44}, 8'h00, '{TYPE_LOCAL_RSP, 8'h21, 8'h42, 8'h44, STATUS_OK, 8'h03});
    host_model_inst.stall = 1'b0;
  endtask

  task automatic t_codes();
    xfer('{TYPE_QUEUED, 8'h17, 8'h54, 8'h50}, 8'h00, '{TYPE_LOCAL_RSP, 8'h17, 8'h54, 8'h50, STATUS_OK, 8'h5a});
    xfer('{TYPE_QUEUED, 8'h18, 8'h54, 8'h50, 8'h01}, 8'h00, '{TYPE_LOCAL_RSP, 8'h18, 8'h54, 8'h50, STATUS_BAD_PARAM});
    xfer('{TYPE_QUEUED, 8'h19, 8'h5a, 8'h5a}, 8'h00, '{TYPE_LOCAL_RSP, 8'h19, 8'h5a, 8'h5a, STATUS_BAD_CMD});
  endtask

  task automatic t_apply();
    xfer('{TYPE_QUEUED, 8'h31, 8'h41, 8'h43}, 8'h00, '{TYPE_LOCAL_RSP, 8'h31, 8'h41, 8'h43, STATUS_OK});
    `chk("rate", 8'h07, serial_rate)
    `chk("active", 16'h0c07, active_values)
    `chk("pending", 1'b0, pending_any)
    xfer('{TYPE_QUEUED, 8'h32, 8'h43, 8'h48, 8'h20}, 8'h00, '{TYPE_LOCAL_RSP, 8'h32, 8'h43, 8'h48, STATUS_OK});
    `chk("active", 16'h0c07, active_values)
    xfer('{TYPE_IMMEDIATE, 8'h33, 8'h42, 8'h44, 8'h05}, 8'h00, '{TYPE_LOCAL_RSP, 8'h33, 8'h42, 8'h44, STATUS_OK});
    `chk("active", 16'h2005, active_values)
    `chk("pending", 1'b0, pending_any)
  endtask

  task automatic t_bad();
    int r;
    r = n_bad;
    host_model_inst.q = '{8'h11, 8'h22};
    xfer('{TYPE_QUEUED, 8'h34, 8'h42, 8'h44, 8'h01}, 8'h5a, '{});
    `chk("bad count", r + 1, n_bad)
    `chk("pending", 1'b0, pending_any)
    xfer('{TYPE_QUEUED, 8'h00, 8'h42, 8'h44, 8'h01}, 8'h00, '{});
    `chk("pending", 1'b1, pending_any)
    xfer('{TYPE_IMMEDIATE, 8'h00, 8'h41, 8'h43}, 8'h00, '{});
    `chk("rate", 8'h01, serial_rate)
  endtask

  task automatic t_remote();
    logic [7:0] opts[4] = '{8'h01, 8'h02, 8'h10, 8'h04};
    logic [7:0] id;
    int r;
    foreach (opts[i])
    begin
      r = n_rreq;
      id = 8'(8'h40 + i);
      xfer(rbody(TYPE_REMOTE, id, DEST, '{opts[i], 8'h54, 8'h50}), 8'h00, '{});
      `chk("remote pulse", r + int'(opts[i] != 8'h04), n_rreq)
      if (opts[i] != 8'h04)
      begin
        `chk("dest", DEST, remote_dest)
        `chk("cmd", MODULE_TEMPERATURE_QUERY, remote_cmd)
        `chk("no ack", opts[i][0], remote_no_ack)
        `chk("apply", opts[i][1], remote_apply)
        `chk("secure", opts[i][4], remote_secure)
        `chk("query", 1'b0, remote_has_value)
        node_rsp(DEST, 1'b1, 8'h33, rbody(TYPE_REMOTE_RSP, id, DEST, '{8'h54, 8'h50, STATUS_OK, 8'h33}));
      end
    end
    xfer(rbody(TYPE_REMOTE, 8'h50, BROADCAST_ADDR, '{8'h00, 8'h42, 8'h44, 8'h09}), 8'h00, '{});
    `chk("no ack", 1'b1, remote_no_ack)
    `chk("apply", 1'b0, remote_apply)
    `chk("value", 8'h09, remote_value)
    node_rsp(DEST, 1'b0, 8'h00, rbody(TYPE_REMOTE_RSP, 8'h50, DEST, '{8'h42, 8'h44, STATUS_OK}));
    node_rsp(~DEST, 1'b0, 8'h00, rbody(TYPE_REMOTE_RSP, 8'h50, ~DEST, '{8'h42, 8'h44, STATUS_OK}));
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_queue();
    t_codes();
    t_apply();
    t_bad();
    t_remote();
    end_sim();
  end

  // whole run needs well under a thousand cycles; this leaves ample margin
  initial
  begin
    repeat (30000) @(posedge clk);
    fails++;
    end_sim();
  end
endmodule // queued_at_command_frame_parser_tb
